// *** logic/gpio_port_bank.sv ***
// The AXI4-Lite interface to the registers is this design's own decision.
module gpio_port_bank
    import gpio_pkg::*;
#(
    parameter logic [NUM_PINS-1:0] OPEN_DRAIN_MASK = '0,
    parameter logic [NUM_REMAP-1:0][PIN_IDX_W-1:0] REMAP_HOME_PIN = pin_map(1'b0),
    parameter logic [NUM_REMAP-1:0][PIN_IDX_W-1:0] REMAP_ALT_PIN = pin_map(1'b1)
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write channels
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read channels
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // port d..i pins, bit 8*port+bit
    input wire logic [NUM_PINS-1:0] pin_in,
    output logic [NUM_PINS-1:0] pin_out,
    output logic [NUM_PINS-1:0] pin_oe_n,
    output logic [NUM_PINS-1:0] pin_pull_up,
    output logic [NUM_PINS-1:0] pin_fast_slope,
    // alternate functions
    input wire logic [NUM_REMAP-1:0] alt_func_out,
    input wire logic [NUM_REMAP-1:0] alt_func_drive,
    output logic [NUM_REMAP-1:0] alt_func_in,
    // special pins
    input wire logic shared_reset_port_pin_in,
    output logic shared_reset_port_pin_out,
    output logic shared_reset_port_pin_oe_n,
    output logic shared_reset_port_pin_pull_up,
    output logic chip_reset_request,
    output logic [1:0] port_b_bit_zero_four_pull_up,
    output logic port_a_bit_zero_pull_up
);
    typedef struct packed {
        logic [NUM_PORTS-1:0][7:0] output_latch;
        logic [NUM_PORTS-1:0][7:0] direction;
        logic [NUM_PORTS-1:0][7:0] control_first;
        logic [NUM_PORTS-1:0][7:0] control_second;
        logic [2:0][7:0] pin_remap;
        logic [7:0] special_ctl;
        logic [NUM_PINS-1:0] sync1;
        logic [NUM_PINS-1:0] sync2;
        logic rst_sync1;
        logic rst_sync2;
        logic aw_held;
        logic [31:0] aw_addr;
        logic w_held;
        logic [7:0] w_byte;
        logic w_lane;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [NUM_PINS-1:0] pin_out;
        logic [NUM_PINS-1:0] pin_oe_n;
        logic [NUM_PINS-1:0] pin_pull;
        logic [NUM_PINS-1:0] pin_fast;
        logic [NUM_REMAP-1:0] alt_in;
        logic rp_out;
        logic rp_oe_n;
        logic rp_pull;
        logic reset_req;
        logic [1:0] pb_pull;
        logic pa0_pull;
    } state_type;

    state_type state_reg;
    state_type state_next;
    logic [NUM_PINS-1:0] alt_sel;
    logic [NUM_PINS-1:0] alt_val;

    // remap routing: each function lands on its home or its alternative pin, never both
    always_comb begin
        alt_sel = '0;
        alt_val = '0;
        for (int f = 0; f < NUM_REMAP; f++) begin
            if (alt_func_drive[f]) begin
                if (state_reg.pin_remap[f / 8][f % 8]) begin
                    alt_sel[REMAP_ALT_PIN[f]] = 1'b1;
                    alt_val[REMAP_ALT_PIN[f]] = alt_func_out[f];
                end else begin
                    alt_sel[REMAP_HOME_PIN[f]] = 1'b1;
                    alt_val[REMAP_HOME_PIN[f]] = alt_func_out[f];
                end
            end
        end
    end

    // next state: bus slave, pin drivers and special pins
    always_comb begin
        logic hit;
        logic [15:0] idx;
        logic [7:0] val;
        logic push_pull;
        state_next = state_reg;
        hit = 1'b0;
        idx = '0;
        val = '0;
        push_pull = 1'b0;
        // pins pass two flops before anything reads them
        state_next.sync1 = pin_in;
        state_next.sync2 = state_reg.sync1;
        state_next.rst_sync1 = shared_reset_port_pin_in;
        state_next.rst_sync2 = state_reg.rst_sync1;

        // write side: address and data taken in either order
        if (state_reg.bvalid && bready) begin
            state_next.bvalid = 1'b0;
        end
        if (awvalid && state_reg.awready) begin
            state_next.aw_held = 1'b1;
            state_next.aw_addr = awaddr;
        end
        if (wvalid && state_reg.wready) begin
            state_next.w_held = 1'b1;
            state_next.w_byte = wdata[7:0];
            state_next.w_lane = wstrb[0];
        end
        if (state_next.aw_held && state_next.w_held && !state_next.bvalid) begin
            idx = state_next.aw_addr[ADDR_IDX_MSB:ADDR_IDX_LSB];
            val = state_next.w_byte;
            hit = ~|state_next.aw_addr[31:ADDR_IDX_MSB+1];
            if (hit) begin
                hit = 1'b0;
                for (int p = 0; p < NUM_PORTS; p++) begin
                    if (idx == OUTPUT_LATCH_IDX[p]) begin
                        hit = 1'b1;
                        if (state_next.w_lane) state_next.output_latch[p] = val;
                    end
                    // input value is read only; a write is answered and dropped
                    if (idx == INPUT_VALUE_IDX[p]) hit = 1'b1;
                    if (idx == DIRECTION_IDX[p]) begin
                        hit = 1'b1;
                        if (state_next.w_lane) state_next.direction[p] = val;
                    end
                    if (idx == CONTROL_FIRST_IDX[p]) begin
                        hit = 1'b1;
                        if (state_next.w_lane) state_next.control_first[p] = val;
                    end
                    if (idx == CONTROL_SECOND_IDX[p]) begin
                        hit = 1'b1;
                        if (state_next.w_lane) state_next.control_second[p] = val;
                    end
                end
                for (int r = 0; r < 3; r++) begin
                    if (idx == PIN_REMAP_IDX[r]) begin
                        hit = 1'b1;
                        if (state_next.w_lane) state_next.pin_remap[r] = val;
                    end
                end
                if (idx == SPECIAL_PIN_CTL_IDX) begin
                    hit = 1'b1;
                    if (state_next.w_lane) state_next.special_ctl = val;
                end
            end
            state_next.aw_held = 1'b0;
            state_next.w_held = 1'b0;
            state_next.bvalid = 1'b1;
            state_next.bresp = hit ? RESP_OKAY : RESP_DECERR;
        end
        state_next.awready = !state_next.aw_held;
        state_next.wready = !state_next.w_held;

        // read side: one read at a time, answer the cycle after the handshake
        if (state_reg.rvalid && rready) begin
            state_next.rvalid = 1'b0;
        end
        if (arvalid && state_reg.arready) begin
            idx = araddr[ADDR_IDX_MSB:ADDR_IDX_LSB];
            hit = 1'b0;
            val = '0;
            if (~|araddr[31:ADDR_IDX_MSB+1]) begin
                for (int p = 0; p < NUM_PORTS; p++) begin
                    if (idx == OUTPUT_LATCH_IDX[p]) begin
                        hit = 1'b1;
                        val = state_reg.output_latch[p];
                    end
                    if (idx == INPUT_VALUE_IDX[p]) begin
                        hit = 1'b1;
                        val = state_reg.sync2[p*8 +: 8];
                    end
                    if (idx == DIRECTION_IDX[p]) begin
                        hit = 1'b1;
                        val = state_reg.direction[p];
                    end
                    if (idx == CONTROL_FIRST_IDX[p]) begin
                        hit = 1'b1;
                        val = state_reg.control_first[p];
                    end
                    if (idx == CONTROL_SECOND_IDX[p]) begin
                        hit = 1'b1;
                        val = state_reg.control_second[p];
                    end
                end
                for (int r = 0; r < 3; r++) begin
                    if (idx == PIN_REMAP_IDX[r]) begin
                        hit = 1'b1;
                        val = state_reg.pin_remap[r];
                    end
                end
                if (idx == SPECIAL_PIN_CTL_IDX) begin
                    hit = 1'b1;
                    val = state_reg.special_ctl;
                end
            end
            state_next.rvalid = 1'b1;
            state_next.rdata = {24'h000000, val};
            state_next.rresp = hit ? RESP_OKAY : RESP_DECERR;
        end
        state_next.arready = !state_next.rvalid;

        // pin drivers; a true open-drain pin loses its high side, pull-up and slope
        for (int i = 0; i < NUM_PINS; i++) begin
            state_next.pin_out[i] = 1'b0;
            state_next.pin_oe_n[i] = 1'b1;
            state_next.pin_pull[i] = 1'b0;
            state_next.pin_fast[i] = 1'b0;
            if (state_reg.direction[i / 8][i % 8]) begin
                val[0] = alt_sel[i] ? alt_val[i] : state_reg.output_latch[i / 8][i % 8];
                push_pull = state_reg.control_first[i / 8][i % 8] && !OPEN_DRAIN_MASK[i];
                if (push_pull) begin
                    state_next.pin_out[i] = val[0];
                    state_next.pin_oe_n[i] = 1'b0;
                end else begin
                    state_next.pin_oe_n[i] = val[0];
                end
                state_next.pin_fast[i] = state_reg.control_second[i / 8][i % 8] &&
                    !OPEN_DRAIN_MASK[i];
            end else begin
                state_next.pin_pull[i] = state_reg.control_first[i / 8][i % 8] &&
                    !OPEN_DRAIN_MASK[i];
            end
        end
        for (int f = 0; f < NUM_REMAP; f++) begin
            state_next.alt_in[f] = state_reg.pin_remap[f / 8][f % 8] ?
                state_reg.sync2[REMAP_ALT_PIN[f]] : state_reg.sync2[REMAP_HOME_PIN[f]];
        end

        // shared reset pin: reset input with pull-up until software claims it
        if (state_reg.special_ctl[SP_PORT_MODE_BIT]) begin
            state_next.rp_out = state_reg.special_ctl[SP_OUT_VALUE_BIT];
            state_next.rp_oe_n = 1'b0;
            state_next.rp_pull = 1'b0;
            state_next.reset_req = 1'b0;
        end else begin
            state_next.rp_out = 1'b0;
            state_next.rp_oe_n = 1'b1;
            state_next.rp_pull = 1'b1;
            state_next.reset_req = !state_reg.rst_sync2;
        end
        state_next.pb_pull = 2'b00;
        state_next.pa0_pull = 1'b1;
    end

    // state register; reset puts only constants into the flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= '0;
            state_reg.output_latch <= {NUM_PORTS{LATCH_RST}};
            state_reg.direction <= {NUM_PORTS{DIRECTION_RST}};
            state_reg.control_first <= {NUM_PORTS{CONTROL_RST}};
            state_reg.control_second <= {NUM_PORTS{CONTROL_RST}};
            state_reg.pin_remap <= {3{REMAP_RST}};
            state_reg.special_ctl <= SPECIAL_RST;
            state_reg.pin_oe_n <= '1;
            state_reg.rp_oe_n <= 1'b1;
            state_reg.rp_pull <= 1'b1;
            state_reg.pb_pull <= 2'b11;
            state_reg.pa0_pull <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from the state flops
    assign awready = state_reg.awready;
    assign wready = state_reg.wready;
    assign bvalid = state_reg.bvalid;
    assign bresp = state_reg.bresp;
    assign arready = state_reg.arready;
    assign rvalid = state_reg.rvalid;
    assign rdata = state_reg.rdata;
    assign rresp = state_reg.rresp;
    assign pin_out = state_reg.pin_out;
    assign pin_oe_n = state_reg.pin_oe_n;
    assign pin_pull_up = state_reg.pin_pull;
    assign pin_fast_slope = state_reg.pin_fast;
    assign alt_func_in = state_reg.alt_in;
    assign shared_reset_port_pin_out = state_reg.rp_out;
    assign shared_reset_port_pin_oe_n = state_reg.rp_oe_n;
    assign shared_reset_port_pin_pull_up = state_reg.rp_pull;
    assign chip_reset_request = state_reg.reset_req;
    assign port_b_bit_zero_four_pull_up = state_reg.pb_pull;
    assign port_a_bit_zero_pull_up = state_reg.pa0_pull;

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    function automatic logic rp_check_in();
        return shared_reset_port_pin_pull_up && shared_reset_port_pin_oe_n;
    endfunction : rp_check_in
    a_resetpin_input_pull: assert property (
        !state_reg.special_ctl[SP_PORT_MODE_BIT] |=> rp_check_in())
        else $error("shared reset pin not a pulled-up input");
    a_resetpin_push_pull: assert property (
        state_reg.special_ctl[SP_PORT_MODE_BIT] |=>
        !shared_reset_port_pin_oe_n && !shared_reset_port_pin_pull_up)
        else $error("shared reset pin port mode not push-pull");
    a_portb_reset_pull: assert property (disable iff (1'b0)
        !aresetn |=> port_b_bit_zero_four_pull_up == 2'b11)
        else $error("port b pull-up missing in reset");
    a_portb_float_after: assert property (
        aresetn ##1 aresetn |-> port_b_bit_zero_four_pull_up == 2'b00)
        else $error("port b pull-up left after reset");
    a_porta_pull_kept: assert property (disable iff (1'b0)
        ##1 port_a_bit_zero_pull_up)
        else $error("port a bit zero pull-up dropped");
    a_slope_reset_limit: assert property (
        $rose(aresetn) |-> ##[0:1] pin_fast_slope == '0)
        else $error("fast slope after reset");
    a_true_od_drive: assert property (
        ((pin_out | pin_pull_up | pin_fast_slope) & OPEN_DRAIN_MASK) == '0)
        else $error("true open-drain pin driven high or pulled");
    a_regs_reset_zero: assert property (
        $rose(aresetn) |-> state_reg.direction == '0 && state_reg.pin_remap == '0)
        else $error("direction or remap not zero after reset");
    a_input_no_drive: assert property (
        (~state_reg.direction & ~alt_sel) == '1 |=> pin_oe_n == '1)
        else $error("pin driven while all inputs");
    a_remap_route_home: assert property (
        alt_func_drive[0] && !state_reg.pin_remap[0][0] && state_reg.direction[0][0] &&
        state_reg.control_first[0][0] |=> pin_out[0] == $past(alt_func_out[0]))
        else $error("remapped function not on its home pin");

    c_write_done: cover property (bvalid && bready && bresp == RESP_OKAY);
    c_read_done: cover property (rvalid && rready && rresp == RESP_OKAY);
    c_unmapped: cover property (rvalid && rresp == RESP_DECERR);
    c_reset_pin_port: cover property (!shared_reset_port_pin_oe_n);
endmodule : gpio_port_bank

// *** logic/gpio_pkg.sv ***
package gpio_pkg;
    localparam int NUM_PORTS = 6;
    localparam int NUM_PINS = 48;
    localparam int NUM_REMAP = 24;
    localparam int PIN_IDX_W = 6;
    // register indices, ports d..i from index 0 upward; byte address is four times index
    localparam logic [NUM_PORTS-1:0][15:0] OUTPUT_LATCH_IDX =
        {16'h5028, 16'h5023, 16'h501e, 16'h5019, 16'h5014, 16'h500f};
    localparam logic [NUM_PORTS-1:0][15:0] INPUT_VALUE_IDX =
        {16'h5029, 16'h5024, 16'h501f, 16'h501a, 16'h5015, 16'h5010};
    localparam logic [NUM_PORTS-1:0][15:0] DIRECTION_IDX =
        {16'h502a, 16'h5025, 16'h5020, 16'h501b, 16'h5016, 16'h5011};
    localparam logic [NUM_PORTS-1:0][15:0] CONTROL_FIRST_IDX =
        {16'h502b, 16'h5026, 16'h5021, 16'h501c, 16'h5017, 16'h5012};
    localparam logic [NUM_PORTS-1:0][15:0] CONTROL_SECOND_IDX =
        {16'h502c, 16'h5027, 16'h5022, 16'h501d, 16'h5018, 16'h5013};
    // remap registers in order first, second, third
    localparam logic [2:0][15:0] PIN_REMAP_IDX = {16'h509d, 16'h509f, 16'h509e};
    localparam logic [15:0] SPECIAL_PIN_CTL_IDX = 16'h50f0;
    localparam int ADDR_IDX_LSB = 2;
    localparam int ADDR_IDX_MSB = 17;
    // special pin control fields
    localparam int SP_PORT_MODE_BIT = 0;
    localparam int SP_OUT_VALUE_BIT = 1;
    // reset values, then the bus response codes
    localparam logic [7:0] LATCH_RST = 8'h00;
    localparam logic [7:0] DIRECTION_RST = 8'h00;
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] REMAP_RST = 8'h00;
    localparam logic [7:0] SPECIAL_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
    // limited output slope, the default after reset
    localparam int SLOPE_LIMIT_MHZ = 2;

    function automatic logic [NUM_REMAP-1:0][PIN_IDX_W-1:0] pin_map(input logic alt);
        logic [NUM_REMAP-1:0][PIN_IDX_W-1:0] m;
        m = '0;
        for (int f = 0; f < NUM_REMAP; f++) begin
            m[f] = alt ? PIN_IDX_W'(NUM_PINS - 1 - f) : PIN_IDX_W'(f);
        end
        return m;
    endfunction : pin_map
endpackage : gpio_pkg

// *** test/board_model.sv ***
module board_model
    import gpio_pkg::*;
(
    // clock
    input wire logic aclk,
    // device pin drive
    input wire logic [NUM_PINS-1:0] pin_out,
    input wire logic [NUM_PINS-1:0] pin_oe_n,
    input wire logic [NUM_PINS-1:0] pin_pull_up,
    output logic [NUM_PINS-1:0] pin_in,
    input wire logic rst_out,
    input wire logic rst_oe_n,
    output logic rst_in,
    // board side drive
    input wire logic [NUM_PINS-1:0] ext_val,
    input wire logic [NUM_PINS-1:0] ext_en,
    input wire logic ext_rst_low
);
    timeunit 1ns;
    timeprecision 1ps;
    logic flip_reg = 1'b0;
    // a floating pin wanders each cycle, so no check can lean on a settled value
    always @(posedge aclk) flip_reg <= !flip_reg;
    // device drive wins, then board drive, then the weak pull-up
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            if (!pin_oe_n[i]) pin_in[i] = pin_out[i];
            else if (ext_en[i]) pin_in[i] = ext_val[i];
            else if (pin_pull_up[i]) pin_in[i] = 1'b1;
            else pin_in[i] = flip_reg ^ i[0];
        end
    end
    // reset pad idles high through its pull-up unless the board pulls it low
    assign rst_in = !rst_oe_n ? rst_out : !ext_rst_low;
endmodule : board_model

// *** test/test_gpio_port_bank.sv ***
module test_gpio_port_bank
    import gpio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
    logic arvalid = 0, arready, rvalid, rready = 0;
    logic [3:0] wstrb = '0;
    logic [1:0] bresp, rresp, pb_pull;
    logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe_n, pin_pull_up, pin_fast_slope;
    logic [NUM_PINS-1:0] ext_val = '0, ext_en = '1;
    logic [NUM_REMAP-1:0] alt_out = '0, alt_drive = '0, alt_in;
    logic sr_in, sr_out, sr_oe_n, sr_pull, rst_req, pa_pull, ext_rst_low = 0;
    int errors = 0, compares = 0, cycles = 0;
    // pin 40 stands in for a true open-drain pad
    localparam logic [NUM_PINS-1:0] OD_MASK = 48'h0100_0000_0000;
    always #2 aclk = !aclk;
    gpio_port_bank #(.OPEN_DRAIN_MASK(OD_MASK)) gpio_port_bank_inst (.aclk(aclk),
        .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_pull_up(pin_pull_up),
        .pin_fast_slope(pin_fast_slope), .alt_func_out(alt_out), .alt_func_drive(alt_drive),
        .alt_func_in(alt_in), .shared_reset_port_pin_in(sr_in),
        .shared_reset_port_pin_out(sr_out), .shared_reset_port_pin_oe_n(sr_oe_n),
        .shared_reset_port_pin_pull_up(sr_pull), .chip_reset_request(rst_req),
        .port_b_bit_zero_four_pull_up(pb_pull), .port_a_bit_zero_pull_up(pa_pull));
    board_model board_model_inst (.aclk(aclk), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pin_pull_up(pin_pull_up), .pin_in(pin_in), .rst_out(sr_out), .rst_oe_n(sr_oe_n),
        .rst_in(sr_in), .ext_val(ext_val), .ext_en(ext_en), .ext_rst_low(ext_rst_low));
    task automatic conclude();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask : chk
    function automatic logic [31:0] ba(input logic [15:0] idx);
        return {14'h0, idx, 2'b00};
    endfunction : ba
    // expected {oe_n, out, pull, fast} of one pin
    function automatic logic [3:0] exp_pin(input logic d, l, c1, c2, od);
        if (!d) return {1'b1, 1'b0, c1 & !od, 1'b0};
        if (c1 && !od) return {1'b0, l, 1'b0, c2};
        return {l, 1'b0, 1'b0, c2 & !od};
    endfunction : exp_pin
    // address and data offered together, each released once taken
    task automatic wr(input logic [15:0] idx, input logic [7:0] d, output logic [1:0] r);
        bit ap, wp, bp;
        ap = 1;
        wp = 1;
        bp = 1;
        awaddr <= ba(idx);
        wdata <= {24'h0, d};
        wstrb <= 4'h1;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (ap || wp || bp) begin
            @(posedge aclk);
            if (ap && awready) begin ap = 0; awvalid <= 0; end
            if (wp && wready) begin wp = 0; wvalid <= 0; end
            // bready stays up after the answer, so a following write never lowers
            // and raises it in one time step
            if (bp && bvalid) begin bp = 0; r = bresp; end
        end
    endtask : wr
    task automatic rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
        bit ap, rp;
        ap = 1;
        rp = 1;
        araddr <= ba(idx);
        arvalid <= 1;
        rready <= 1;
        while (ap || rp) begin
            @(posedge aclk);
            if (ap && arready) begin ap = 0; arvalid <= 0; end
            // rready stays up for the same reason as bready
            if (rp && rvalid) begin rp = 0; d = rdata; r = rresp; end
        end
    endtask : rd
    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin errors++; conclude(); end
    end
    initial begin
        logic [7:0] d, l, c1, c2, e, ein;
        logic [3:0] x, m, g;
        logic [31:0] rv;
        logic [1:0] r;
        int p, k;
        void'($urandom(32'h512a));
        repeat (4) @(posedge aclk);
        chk(32'(pb_pull), 32'h3, "port b pulls in reset");
        chk(32'({pa_pull, sr_pull, sr_oe_n}), 32'h7, "pa0 and reset pad pulls");
        @(posedge aclk);
        aresetn <= 1;
        repeat (3) @(posedge aclk);
        chk(32'({pb_pull, pa_pull, sr_pull}), 32'h3, "pulls after release");
        chk(32'(pin_fast_slope), 32'h0, "slope default");
        for (p = 0; p < NUM_PORTS; p++) begin
            rd(OUTPUT_LATCH_IDX[p], rv, r); chk(rv, 32'h0, "latch reset");
            rd(DIRECTION_IDX[p], rv, r); chk(rv, 32'h0, "direction reset");
            rd(CONTROL_FIRST_IDX[p], rv, r); chk(rv, 32'h0, "ctl1 reset");
            rd(CONTROL_SECOND_IDX[p], rv, r); chk(rv, 32'h0, "ctl2 reset");
        end
        for (p = 0; p < 3; p++) begin
            rd(PIN_REMAP_IDX[p], rv, r); chk(rv, 32'h0, "remap reset");
        end
        rd(16'h5000, rv, r); chk(rv, 32'h0, "unmapped read");
        chk(32'(r), 32'(RESP_DECERR), "unmapped read resp");
        wr(16'h5000, 8'h5a, r); chk(32'(r), 32'(RESP_DECERR), "unmapped write");
        for (int i = 0; i < 18; i++) begin
            p = i % NUM_PORTS;
            d = 8'($urandom);
            l = 8'($urandom);
            c1 = 8'($urandom);
            c2 = 8'($urandom);
            e = 8'($urandom);
            ext_val[8*p +: 8] <= e;
            wr(DIRECTION_IDX[p], d, r);
            wr(OUTPUT_LATCH_IDX[p], l, r);
            wr(CONTROL_FIRST_IDX[p], c1, r);
            wr(CONTROL_SECOND_IDX[p], c2, r); chk(32'(r), 32'(RESP_OKAY), "write resp");
            repeat (4) @(posedge aclk);
            for (int b = 0; b < 8; b++) begin
                k = 8 * p + b;
                x = exp_pin(d[b], l[b], c1[b], c2[b], OD_MASK[k]);
                m = d[b] ? 4'hf : 4'ha;
                g = {pin_oe_n[k], pin_out[k], pin_pull_up[k], pin_fast_slope[k]};
                chk(32'(g & m), 32'(x & m), "pin mode");
                ein[b] = x[3] ? e[b] : x[2];
            end
            rd(INPUT_VALUE_IDX[p], rv, r); chk(rv, {24'h0, ein}, "input value");
            chk(32'(r), 32'(RESP_OKAY), "read resp");
            rd(OUTPUT_LATCH_IDX[p], rv, r); chk(rv, {24'h0, l}, "latch hold");
        end
        wr(DIRECTION_IDX[0], 8'h01, r);
        wr(CONTROL_FIRST_IDX[0], 8'h01, r);
        wr(OUTPUT_LATCH_IDX[0], 8'h00, r);
        wr(DIRECTION_IDX[5], 8'h80, r);
        wr(CONTROL_FIRST_IDX[5], 8'h80, r);
        wr(OUTPUT_LATCH_IDX[5], 8'h00, r);
        alt_drive[0] <= 1;
        alt_out[0] <= 1;
        repeat (4) @(posedge aclk);
        chk(32'({pin_out[0], pin_out[47]}), 32'h2, "function on home pin");
        wr(PIN_REMAP_IDX[0], 8'h01, r);
        repeat (4) @(posedge aclk);
        chk(32'({pin_out[0], pin_out[47], alt_in[0]}), 32'h3, "function moved");
        // port f bit 7 stands for an unbonded bit: software gives it the pull-up
        ext_en[23] <= 1'b0;
        wr(DIRECTION_IDX[2], 8'h00, r);
        wr(CONTROL_FIRST_IDX[2], 8'h80, r);
        repeat (4) @(posedge aclk);
        rd(INPUT_VALUE_IDX[2], rv, r); chk(32'(rv[7]), 32'h1, "unbonded bit pulled");
        ext_rst_low <= 1;
        repeat (4) @(posedge aclk);
        chk(32'(rst_req), 32'h1, "reset pad request");
        ext_rst_low <= 0;
        wr(SPECIAL_PIN_CTL_IDX, 8'h03, r);
        repeat (4) @(posedge aclk);
        chk(32'({sr_oe_n, sr_out, sr_pull}), 32'h2, "reset pad as output");
        conclude();
    end
endmodule : test_gpio_port_bank
